// *** core/serial_ir_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "link_regs.svh"
module serial_ir_ctrl (
  input wire logic clk, // System clock, 100 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic [2:0] addr, // Register offset
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic dma_rd, // DMA read of receive data
  input wire logic rx_line, // Serial receive input
  input wire logic fifo_enable, // FIFOs enabled
  input wire logic rx_soft_reset, // Receiver soft reset pulse
  input wire logic tx_ready, // Transmit holding empty
  input wire logic tx_empty, // Transmitter fully idle
  input wire logic ls_int_enable, // Link status interrupt enable
  input wire logic irq_request, // Interrupt from source logic
  input wire logic cts_n, // Clear to send pin
  input wire logic dsr_n, // Data set ready pin
  input wire logic ri_n, // Ring indicate pin
  input wire logic dcd_n, // Carrier detect pin
  output logic dtr_n, // Terminal ready pin
  output logic rts_n, // Request to send pin
  output logic [3:0] modem_lines, // {dcd,ri,dsr,cts}, active high
  output logic irq_out, // Gated interrupt output
  output logic ls_irq, // Link status interrupt pending
  output logic [7:0] link_control, // Character format register
  output logic [2:0] bank_selected, // Decoded bank
  output logic bank_reserved, // Bank code is reserved
  output link_pkg::op_mode_t operating_mode, // Effective mode
  output logic dma_enable, // DMA operation enabled
  output logic transmit_deferral, // Deferral in effect
  output logic fifo_flush, // Flush both FIFOs, pulse
  output logic aux_clear, // Clear auxiliary register, pulse
  output logic loopback // Loopback active
);
  import link_pkg::*;
  localparam logic [7:0] LS_RST = `LS_RESET;
  localparam logic [15:0] BAUD_DIV = 16'(`BAUD16_DIV);
  localparam int DEPTH = int'(`FIFO_DEPTH);
  // ---------------------------------------------------------------
  // Bank decoding
  // ---------------------------------------------------------------
  // Returns {reserved, bank}
  function automatic logic [3:0] bank_of(input logic [7:0] b);
    logic [3:0] r;
    r = 4'h8;
    if (!b[`BSE_BIT]) begin
      r = 4'h0;
    end else if (!b[6] || b[1] || b[0]) begin
      r = 4'h1;
    end else if (b[5] && (b[4:2] < 3'h6)) begin
      r = {1'b0, 3'(b[4:2] + 3'h2)};
    end
    return r;
  endfunction : bank_of

  logic [7:0] bank_q;
  logic [7:0] lcr_q;
  logic [3:0] ctl_q;
  logic loop_q;
  logic ext_q;
  op_mode_t mode_q;
  wire logic [3:0] cur_bank = bank_of(bank_q);
  wire logic [3:0] new_bank = bank_of(wdata);
  wire logic in_bank0 = (cur_bank == 4'h0);
  wire logic in_xbank = (cur_bank == {1'b0, `BANK_XCTL});

  // Address selects, offset 3 answers in every bank
  wire logic sel_bank = (addr == `OFF_BANK);
  wire logic sel_data = in_bank0 && (addr == `OFF_DATA);
  wire logic sel_mode = in_bank0 && (addr == `OFF_MODE_CTL);
  wire logic sel_stat = in_bank0 && (addr == `OFF_LSTAT);
  wire logic sel_xctl = in_xbank && (addr == `OFF_XCTL);

  wire logic wr_bank = wr && sel_bank;
  wire logic wr_mode = wr && sel_mode;
  wire logic wr_xctl = wr && sel_xctl;
  wire logic rd_stat = rd && sel_stat;
  // The status register has no write path at all
  wire logic wr_stat_ignored = wr && sel_stat;

  // Format register only follows codes for banks 0 and 1
  wire logic lcr_take = wr_bank && (new_bank[3:2] == 2'b00) && !new_bank[1];

  // Mode field changes only through the extended view
  wire logic mode_chg = wr_mode && ext_q && (wdata[7:5] != mode_q);

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bank_q <= `CTL_RESET;
      lcr_q <= `CTL_RESET;
      ctl_q <= 4'h0;
      loop_q <= 1'b0;
      ext_q <= 1'b0;
      mode_q <= MODE_SERIAL;
    end else begin
      if (wr_bank) bank_q <= wdata;
      if (lcr_take) lcr_q <= wdata;
      if (wr_mode) begin
        ctl_q <= wdata[3:0];
        // Legacy view owns loopback, extended view owns the mode
        if (!ext_q) loop_q <= wdata[`MODE_LOOP_BIT];
        else mode_q <= op_mode_t'(wdata[7:5]);
      end
      if (wr_xctl) begin
        ext_q <= wdata[`XCTL_EXT_BIT];
        loop_q <= wdata[`XCTL_LOOP_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Derived control
  // ---------------------------------------------------------------
  wire op_mode_t eff_mode = ext_q ? mode_q : MODE_SERIAL;
  // Parity, framing and break only mean something in framed modes
  wire logic framed = (eff_mode == MODE_SERIAL) || (eff_mode == MODE_ASK_IR) ||
                      (eff_mode == MODE_SER_IR);
  // Remote-control mode always runs with FIFOs on
  wire logic fifo_on = fifo_enable || (eff_mode == MODE_REMOTE_IR);
  wire logic gate_on = ext_q || loop_q || ctl_q[3];

  assign operating_mode = eff_mode;
  assign loopback = loop_q;
  assign link_control = lcr_q;
  assign bank_selected = cur_bank[2:0];
  assign bank_reserved = cur_bank[3];
  assign dma_enable = ext_q && ctl_q[2];
  assign transmit_deferral = ext_q && ctl_q[3] && fifo_enable;
  assign irq_out = irq_request && gate_on;

  // Modem lines seen by status logic, active high
  wire logic [3:0] loop_legacy = {ctl_q[3], ctl_q[2], ctl_q[0], ctl_q[1]};
  wire logic [3:0] loop_ext = {ctl_q[1], ctl_q[0], ctl_q[0], ctl_q[1]};
  wire logic [3:0] pin_lines = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
  wire logic [3:0] lines_d = !loop_q ? pin_lines : (ext_q ? loop_ext : loop_legacy);

  // ---------------------------------------------------------------
  // Pin and pulse outputs
  // ---------------------------------------------------------------
  // Pins idle high in loopback since the modem side is cut off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      modem_lines <= 4'h0;
      fifo_flush <= 1'b0;
      aux_clear <= 1'b0;
    end else begin
      dtr_n <= !(ctl_q[0] && !loop_q);
      rts_n <= !(ctl_q[1] && !loop_q);
      modem_lines <= lines_d;
      fifo_flush <= mode_chg;
      aux_clear <= mode_chg;
    end
  end

  // ---------------------------------------------------------------
  // Receiver and bit rate divider
  // ---------------------------------------------------------------
  logic [15:0] div_q;
  wire logic tick = (div_q == BAUD_DIV - 16'h1);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) div_q <= 16'h0000;
    else div_q <= tick ? 16'h0000 : div_q + 16'h1;
  end

  logic rx_done;
  logic [7:0] rx_data;
  logic rx_perr;
  logic rx_ferr;
  logic rx_brk;
  link_rx u_rx (
    .clk(clk),
    .nrst(nrst),
    .clear(rx_soft_reset),
    .tick(tick),
    .line(loop_q ? 1'b1 : rx_line),
    .wls(lcr_q[1:0]),
    .pen(lcr_q[3]),
    .eps(lcr_q[4]),
    .stk(lcr_q[5]),
    .done(rx_done),
    .data(rx_data),
    .perr(rx_perr),
    .ferr(rx_ferr),
    .brk(rx_brk)
  );

  // ---------------------------------------------------------------
  // Receive store: one-entry holding register or full FIFO
  // ---------------------------------------------------------------
  // Each entry carries {break, framing, parity, data}
  logic [10:0] mem_q [DEPTH];
  logic [3:0] wp_q;
  logic [3:0] rp_q;
  logic [4:0] cnt_q;
  wire logic [10:0] rx_word = {rx_brk, rx_ferr, rx_perr, rx_data};
  wire logic [4:0] cap = fifo_on ? `FIFO_DEPTH : 5'h01;
  wire logic full = (cnt_q >= cap);
  wire logic flush = mode_chg || rx_soft_reset;
  wire logic data_rd = dma_rd || (rd && sel_data);
  wire logic pop = data_rd && (cnt_q != 5'h00);
  wire logic push = rx_done && !full;
  wire logic overrun = rx_done && full;
  // A character reaches the head when pushed into an empty store or
  // when the entry in front of it is popped
  wire logic many = (cnt_q > 5'h01);
  wire logic reveal = (pop && (many || push)) || (push && (cnt_q == 5'h00));
  wire logic [10:0] head_next = (pop && many) ? mem_q[rp_q + 4'h1] : rx_word;
  wire logic [10:0] head = mem_q[rp_q];

  always_ff @(posedge clk) begin
    if (push) mem_q[wp_q] <= rx_word;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= 4'h0;
      rp_q <= 4'h0;
      cnt_q <= 5'h00;
    end else if (flush) begin
      wp_q <= 4'h0;
      rp_q <= 4'h0;
      cnt_q <= 5'h00;
    end else begin
      if (push) wp_q <= wp_q + 4'h1;
      if (pop) rp_q <= rp_q + 4'h1;
      cnt_q <= cnt_q + {4'h0, push} - {4'h0, pop};
    end
  end

  // ---------------------------------------------------------------
  // Link status
  // ---------------------------------------------------------------
  logic [3:0] err_q; // {break, framing, parity, overrun}
  logic txrdy_q;
  logic txemp_q;
  logic ls_pend_q;
  wire logic show = reveal && framed && !flush;
  // Break, framing and parity errors become visible only when their character is at the head; overrun is set at once
  wire logic [3:0] err_set = {show && head_next[10], // break
                              show && head_next[9],
                              show && head_next[8],
                              overrun && !flush};
  wire logic err_clr = rd_stat || rx_soft_reset;
  // New events win over a status-read clear in the same cycle
  wire logic [3:0] err_d = (err_q & ~{4{err_clr}}) | err_set;
  wire logic pend_clr = rd_stat || rx_soft_reset || mode_chg;
  wire logic pend_d = (ls_pend_q && !pend_clr) || (|err_set);
  wire logic rx_avail = (cnt_q != 5'h00);
  wire logic [7:0] lstat = {1'b0, txemp_q, txrdy_q, err_q, rx_avail};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_q <= LS_RST[4:1];
      txrdy_q <= LS_RST[5];
      txemp_q <= LS_RST[6];
      ls_pend_q <= 1'b0;
    end else begin
      err_q <= err_d;
      txrdy_q <= tx_ready;
      txemp_q <= tx_empty;
      ls_pend_q <= pend_d;
    end
  end
  assign ls_irq = ls_pend_q && ls_int_enable;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  wire logic [7:0] mode_view = ext_q ? {mode_q, 1'b0, ctl_q} : {3'h0, loop_q, ctl_q};
  wire logic [7:0] xctl_view = {3'h0, loop_q, 3'h0, ext_q};
  wire logic [7:0] head_data = (cnt_q != 5'h00) ? head[7:0] : 8'h00;
  wire logic [7:0] rd_val = dma_rd ? head_data :
                            sel_bank ? bank_q :
                            sel_data ? head_data :
                            sel_mode ? mode_view :
                            sel_stat ? lstat :
                            sel_xctl ? xctl_view : 8'h00;

  // Data stand for exactly the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rdata <= 8'h00;
    else rdata <= (rd || dma_rd) ? rd_val : 8'h00;
  end

  // Unused in logic: a status write is dropped on purpose
  wire logic unused_ok = wr_stat_ignored;

endmodule : serial_ir_ctrl
`default_nettype wire

// *** core/link_regs.svh ***
`ifndef LINK_REGS_SVH
`define LINK_REGS_SVH
`define OFF_DATA 3'h0
`define OFF_XCTL 3'h2
`define OFF_BANK 3'h3
`define OFF_MODE_CTL 3'h4
`define OFF_LSTAT 3'h5
`define BANK_XCTL 3'h2
`define XCTL_EXT_BIT 0
`define XCTL_LOOP_BIT 4
`define MODE_LOOP_BIT 4
`define BSE_BIT 7
`define LS_RESET 8'h60
`define CTL_RESET 8'h00
`define FIFO_DEPTH 5'h10
`define CLK_HZ 100000000
`define BAUD_HZ 115200
`define BAUD16_DIV (`CLK_HZ / (`BAUD_HZ * 16))
`define MID_TICK 4'h7
`define END_TICK 4'hf
`endif

// *** core/link_pkg.sv ***
package link_pkg;
  // Receiver states, one-hot
  typedef enum logic [5:0] {
    RX_IDLE = 6'h01,
    RX_START = 6'h02,
    RX_DATA = 6'h04,
    RX_PAR = 6'h08,
    RX_STOP = 6'h10,
    RX_RESYNC = 6'h20
  } rx_state_t;
  // Operating modes of the mode field
  typedef enum logic [2:0] {
    MODE_SERIAL = 3'h0,
    MODE_ASK_IR = 3'h2,
    MODE_SER_IR = 3'h3,
    MODE_REMOTE_IR = 3'h6
  } op_mode_t;
endpackage : link_pkg

// *** core/link_rx.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "link_regs.svh"
module link_rx (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic clear, // Soft reset of the receiver
  input wire logic tick, // 16x bit rate enable
  input wire logic line, // Serial input, idle high
  input wire logic [1:0] wls, // Character length code
  input wire logic pen, // Parity enable
  input wire logic eps, // Even parity select
  input wire logic stk, // Stick parity
  output logic done, // Character complete pulse
  output logic [7:0] data, // Received character
  output logic perr, // Parity mismatch
  output logic ferr, // Stop bit was zero
  output logic brk // All-zero frame
);
  import link_pkg::*;
  rx_state_t state_q;
  logic [3:0] cnt_q;
  logic [2:0] idx_q;
  logic [7:0] sh_q;
  logic px_q;
  logic pbit_q;
  wire logic mid = tick && (cnt_q == `MID_TICK);
  wire logic edge_end = tick && (cnt_q == `END_TICK);
  wire logic last_bit = (idx_q == {1'b1, wls});
  wire logic par_exp = stk ? ~eps : (eps ? px_q : ~px_q);
  // Data is shifted in LSB first, so short characters need realigning
  wire logic [7:0] aligned = sh_q >> (2'h3 - wls);
  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= RX_IDLE;
      cnt_q <= 4'h0;
      idx_q <= 3'h0;
      sh_q <= 8'h00;
      px_q <= 1'b0;
      pbit_q <= 1'b0;
      done <= 1'b0;
      data <= 8'h00;
      perr <= 1'b0;
      ferr <= 1'b0;
      brk <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tick) cnt_q <= cnt_q + 4'h1;
      if (clear) begin
        state_q <= RX_IDLE;
      end else begin
        case (state_q)
          RX_IDLE: if (!line) begin
            state_q <= RX_START;
            cnt_q <= 4'h0;
          end
          RX_START: if (mid) begin
            state_q <= line ? RX_IDLE : RX_DATA;
            cnt_q <= 4'h0;
            idx_q <= 3'h0;
            px_q <= 1'b0;
          end
          RX_DATA: if (edge_end) begin
            sh_q <= {line, sh_q[7:1]};
            px_q <= px_q ^ line;
            idx_q <= idx_q + 3'h1;
            if (last_bit) state_q <= pen ? RX_PAR : RX_STOP;
          end
          RX_PAR: if (edge_end) begin
            pbit_q <= line;
            state_q <= RX_STOP;
          end
          RX_STOP: if (edge_end) begin
            done <= 1'b1;
            data <= aligned;
            perr <= pen && (pbit_q != par_exp);
            ferr <= !line;
            brk <= !line && (aligned == 8'h00) && !(pen && pbit_q);
            // A bad stop bit is followed by a resync look at the next bit
            state_q <= line ? RX_IDLE : RX_RESYNC;
          end
          RX_RESYNC: if (edge_end) begin
            // A zero here is taken as a start bit already centred
            state_q <= line ? RX_IDLE : RX_DATA;
            idx_q <= 3'h0;
            px_q <= 1'b0;
          end
          default: state_q <= RX_IDLE;
        endcase
      end
    end
  end
endmodule : link_rx
`default_nettype wire

// *** tb/serial_ir_ctrl_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module serial_ir_ctrl_chk
  import link_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic nrst, // Reset
  input wire logic [2:0] addr, // Offset
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [7:0] rdata, // Read data
  input wire logic dma_rd, // DMA read
  input wire logic fifo_enable, // FIFO on
  input wire logic ls_int_enable, // Status irq enable
  input wire logic irq_request, // Irq source
  input wire logic dtr_n, // Terminal ready
  input wire logic rts_n, // Request to send
  input wire logic irq_out, // Gated irq
  input wire logic ls_irq, // Status irq
  input wire logic [7:0] link_control, // Format
  input wire logic [2:0] bank_selected, // Bank
  input wire logic bank_reserved, // Reserved code
  input wire link_pkg::op_mode_t operating_mode, // Mode
  input wire logic transmit_deferral, // Deferral
  input wire logic fifo_flush, // Flush pulse
  input wire logic aux_clear, // Aux clear pulse
  input wire logic loopback // Loopback
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Mode change, then both clear pulses within a cycle
  sequence s_mode_change;
    $changed(operating_mode);
  endsequence
  sequence s_flush_pair;
    ##[0:1] (fifo_flush && aux_clear);
  endsequence
  a_mode_flush: assert property (s_mode_change |-> s_flush_pair)
    else $error("mode change without flush");
  a_flush_pair: assert property (fifo_flush == aux_clear)
    else $error("flush and aux clear apart");
  a_flush_once: assert property (fifo_flush && !(wr && addr == 3'h4) |=> !fifo_flush)
    else $error("flush pulse too long");
  a_loop_pins: assert property (loopback && $past(loopback) |-> dtr_n && rts_n)
    else $error("modem outputs driven in loopback");
  a_irq_source: assert property (irq_out |-> irq_request)
    else $error("irq without source");
  a_irq_forced: assert property (irq_request && (loopback
    || operating_mode != MODE_SERIAL) |-> irq_out)
    else $error("irq gated while forced on");
  // Read data only in the cycle after a read
  a_rdata_idle: assert property ($past(nrst) && !$past(rd) && !$past(dma_rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_lc_write: assert property (wr && addr == 3'h3 && (!wdata[7] || !wdata[6] || wdata[1]
    || wdata[0]) |=> link_control == $past(wdata))
    else $error("link control not written");
  a_lc_keep: assert property (wr && addr == 3'h3 && wdata[7:5] == 3'h7 && wdata[1:0] == 2'h0
    && !(wdata[4] && wdata[3]) |=> $stable(link_control))
    else $error("link control written by bank code");
  a_bank_zero: assert property (wr && addr == 3'h3 && !wdata[7]
    |=> bank_selected == 3'h0 && !bank_reserved)
    else $error("bank zero not selected");
  a_bank_one: assert property (wr && addr == 3'h3 && wdata[7:6] == 2'h2
    |=> bank_selected == 3'h1 && !bank_reserved)
    else $error("bank one not selected");
  a_defer_fifo: assert property (transmit_deferral |-> fifo_enable)
    else $error("deferral without fifo");
  a_ls_gate: assert property (ls_irq |-> ls_int_enable)
    else $error("status irq not gated");
endmodule : serial_ir_ctrl_chk
bind serial_ir_ctrl serial_ir_ctrl_chk serial_ir_ctrl_chk_inst (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .dma_rd(dma_rd), .fifo_enable(fifo_enable), .ls_int_enable(ls_int_enable),
  .irq_request(irq_request), .dtr_n(dtr_n), .rts_n(rts_n), .irq_out(irq_out),
  .ls_irq(ls_irq), .link_control(link_control), .bank_selected(bank_selected),
  .bank_reserved(bank_reserved), .operating_mode(operating_mode),
  .transmit_deferral(transmit_deferral), .fifo_flush(fifo_flush), .aux_clear(aux_clear),
  .loopback(loopback)
);
`default_nettype wire

// *** tb/link_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "link_regs.svh"
// ----
// Modem side model
// ----
module link_far_end (
  input wire logic clk, // System clock
  output logic rx_line, // Serial data, idle high
  output logic cts_n, // Clear to send
  output logic dsr_n, // Data set ready
  output logic ri_n, // Ring indicate
  output logic dcd_n // Carrier detect
);
  localparam int BIT_CLKS = `BAUD16_DIV * 16;
  // Line idles high, all pins inactive
  initial begin
    rx_line <= 1'b1;
    {dcd_n, ri_n, dsr_n, cts_n} <= 4'hf;
  end
  // Frames go out lsb first; line returns high after
  task automatic send_bits(input logic [21:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_line <= bits[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    @(posedge clk);
    rx_line <= 1'b1;
  endtask : send_bits
  // Pins given as {dcd, ri, dsr, cts}, active low
  task automatic set_pins(input logic [3:0] p);
    @(posedge clk);
    {dcd_n, ri_n, dsr_n, cts_n} <= p;
  endtask : set_pins
endmodule : link_far_end
`default_nettype wire

// *** tb/serial_ir_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_ir_ctrl_test;
  import link_pkg::*;
  localparam logic [7:0] CODES [13] = '{8'h00, 8'h45, 8'h80, 8'hc2, 8'hc1, 8'he0, 8'he4,
    8'he8, 8'hec, 8'hf0, 8'hf4, 8'hf8, 8'hd0};
  localparam logic [3:0] BANKS [13] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
    4'h6, 4'h7, 4'h8, 4'h8};
  localparam logic [2:0] MODES [4] = '{3'h2, 3'h3, 3'h6, 3'h0};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic dma_rd = 1'b0;
  logic fifo_enable = 1'b0;
  logic rx_soft_reset = 1'b0;
  logic ls_int_enable = 1'b0;
  logic tx_ready = 1'b1;
  logic tx_empty = 1'b1;
  logic irq_request = 1'b1;
  wire logic rx_line, cts_n, dsr_n, ri_n, dcd_n;
  logic [7:0] rdata, link_control, lc;
  logic dtr_n, rts_n, irq_out, ls_irq, bank_reserved, dma_enable;
  logic transmit_deferral, fifo_flush, aux_clear, loopback;
  logic [3:0] modem_lines;
  logic [2:0] bank_selected;
  op_mode_t operating_mode;
  int n_fail = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  serial_ir_ctrl serial_ir_ctrl_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .dma_rd(dma_rd), .rx_line(rx_line),
    .fifo_enable(fifo_enable), .rx_soft_reset(rx_soft_reset), .tx_ready(tx_ready),
    .tx_empty(tx_empty), .ls_int_enable(ls_int_enable), .irq_request(irq_request),
    .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .dtr_n(dtr_n), .rts_n(rts_n),
    .modem_lines(modem_lines), .irq_out(irq_out), .ls_irq(ls_irq),
    .link_control(link_control), .bank_selected(bank_selected),
    .bank_reserved(bank_reserved), .operating_mode(operating_mode), .dma_enable(dma_enable),
    .transmit_deferral(transmit_deferral), .fifo_flush(fifo_flush), .aux_clear(aux_clear),
    .loopback(loopback));
  link_far_end link_far_end_inst (.clk(clk), .rx_line(rx_line), .cts_n(cts_n),
    .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));
  // ----
  // Bus tasks and checks
  // ----
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Plain writes; the status offset is never a target
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Data is looked at only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, exp, rdata);
  endtask : rd_chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Bounded look for the flush pulse
  task automatic wait_flush();
    logic seen;
    seen = 1'b0;
    repeat (3) begin
      #1;
      if (fifo_flush === 1'b1 && aux_clear === 1'b1) seen = 1'b1;
      @(posedge clk);
    end
    check("flush seen", 8'h01, {7'h0, seen});
  endtask : wait_flush
  // Start bit, data lsb first, parity, stop
  function automatic logic [10:0] frame(input logic [7:0] d, input logic p, input logic s);
    return {s, p, d, 1'b0};
  endfunction : frame
  task automatic send(input logic [10:0] f);
    link_far_end_inst.send_bits({11'h7ff, f}, 11);
    tick(4);
  endtask : send
  task automatic wrap_up();
    $display("Checks made %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  // Main sequence; receive part uses 8 bits, even parity
  initial begin
    lc = 8'h00;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(3'h5, 8'h60, "status reset");
    for (int i = 0; i < 13; i++) begin
      wr_reg(3'h3, CODES[i]);
      #1;
      if (!CODES[i][7] || !CODES[i][6] || CODES[i][1] || CODES[i][0]) lc = CODES[i];
      check("link control", lc, link_control);
      check("reserved", {7'h0, BANKS[i] == 4'h8}, {7'h0, bank_reserved});
      if (BANKS[i] != 4'h8) check("bank", {4'h0, BANKS[i]}, {5'h0, bank_selected});
      rd_chk(3'h3, CODES[i], "bank select");
    end
    wr_reg(3'h3, 8'h03);
    wr_reg(3'h4, 8'h0b);
    tick(2);
    check("dtr rts", 8'h00, {6'h0, dtr_n, rts_n});
    check("irq on", 8'h01, {7'h0, irq_out});
    wr_reg(3'h4, 8'h00);
    tick(2);
    check("irq off", 8'h00, {7'h0, irq_out});
    wr_reg(3'h4, 8'hff);
    rd_chk(3'h4, 8'h1f, "legacy control");
    check("loop modem", 8'h0f, {4'h0, modem_lines});
    check("loop irq", 8'h01, {7'h0, irq_out});
    wr_reg(3'h4, 8'h15);
    tick(2);
    check("loop modem", 8'h06, {4'h0, modem_lines});
    wr_reg(3'h3, 8'he0);
    rd_chk(3'h2, 8'h10, "shared loop bit");
    wr_reg(3'h2, 8'h00);
    wr_reg(3'h3, 8'h03);
    rd_chk(3'h4, 8'h05, "legacy control");
    link_far_end_inst.set_pins(4'he);
    tick(3);
    check("modem pins", 8'h01, {4'h0, modem_lines});
    wr_reg(3'h3, 8'he0);
    wr_reg(3'h2, 8'h01);
    wr_reg(3'h3, 8'h03);
    wr_reg(3'h4, 8'h0c);
    tick(2);
    check("ext irq", 8'h01, {7'h0, irq_out});
    check("dma", 8'h01, {7'h0, dma_enable});
    check("defer off", 8'h00, {7'h0, transmit_deferral});
    @(posedge clk) fifo_enable <= 1'b1;
    tick(1);
    check("defer on", 8'h01, {7'h0, transmit_deferral});
    @(posedge clk) fifo_enable <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr_reg(3'h4, {MODES[i], 5'h00});
      wait_flush();
      check("mode", {5'h0, MODES[i]}, {5'h0, operating_mode});
      rd_chk(3'h4, {MODES[i], 5'h00}, "mode control");
    end
    wr_reg(3'h4, 8'h11);
    rd_chk(3'h4, 8'h01, "ext control");
    check("no loop", 8'h00, {7'h0, loopback});
    wr_reg(3'h3, 8'he0);
    wr_reg(3'h2, 8'h11);
    wr_reg(3'h3, 8'h03);
    wr_reg(3'h4, 8'h01);
    tick(2);
    check("ext loop modem", 8'h06, {4'h0, modem_lines});
    wr_reg(3'h4, 8'h02);
    tick(2);
    check("ext loop modem", 8'h09, {4'h0, modem_lines});
    wr_reg(3'h3, 8'he0);
    wr_reg(3'h2, 8'h00);
    wr_reg(3'h3, 8'h1b);
    @(posedge clk) ls_int_enable <= 1'b1;
    send(frame(8'h55, 1'b0, 1'b1));
    rd_chk(3'h5, 8'h61, "status data");
    rd_chk(3'h0, 8'h55, "rx data");
    rd_chk(3'h5, 8'h60, "status empty");
    @(posedge clk) {tx_ready, tx_empty} <= 2'b00;
    rd_chk(3'h5, 8'h00, "status tx busy");
    @(posedge clk) {tx_ready, tx_empty} <= 2'b11;
    send(frame(8'ha5, 1'b1, 1'b1));
    check("ls irq", 8'h01, {7'h0, ls_irq});
    rd_chk(3'h5, 8'h65, "status parity");
    rd_chk(3'h5, 8'h61, "status cleared");
    rd_chk(3'h0, 8'ha5, "rx data");
    link_far_end_inst.send_bits({frame(8'h42, 1'b0, 1'b1), frame(8'h31, 1'b1, 1'b0)}, 22);
    tick(4);
    rd_chk(3'h5, 8'h6b, "status frame overrun");
    rd_chk(3'h0, 8'h31, "kept data");
    rd_chk(3'h5, 8'h60, "status empty");
    wr_reg(3'h3, 8'he0);
    send(frame(8'h3c, 1'b1, 1'b1));
    @(posedge clk) dma_rd <= 1'b1;
    @(posedge clk) dma_rd <= 1'b0;
    #1;
    check("dma data", 8'h3c, rdata);
    @(posedge clk) rx_soft_reset <= 1'b1;
    @(posedge clk) rx_soft_reset <= 1'b0;
    wr_reg(3'h3, 8'h1b);
    rd_chk(3'h5, 8'h60, "status soft reset");
    wrap_up();
  end
endmodule : serial_ir_ctrl_test
`default_nettype wire
